//--- design/cap_pkg.sv
package cap_pkg;

  // Register byte offsets inside the 4 KB slave window
  localparam int OFF_W = 12;
  localparam logic [OFF_W-1:0] OFF_DEVICE_ID_ONE = 12'h004;
  localparam logic [OFF_W-1:0] OFF_MEM_SIZE = 12'h008;
  localparam logic [OFF_W-1:0] OFF_FEATURE_ONE = 12'h010;
  localparam logic [OFF_W-1:0] OFF_PERIPH_TWO = 12'h014;
  localparam int WORD_LSB = 2;

  // Identification word layout
  localparam int ID_VER_POS = 28;
  localparam int ID_VER_W = 4;
  localparam logic [3:0] ID_VER_VALUE = 4'h1;
  localparam int ID_FAM_POS = 24;
  localparam int ID_FAM_W = 4;
  localparam int ID_PART_POS = 16;
  localparam int ID_PART_W = 8;
  localparam int ID_PIN_POS = 13;
  localparam int ID_PIN_W = 3;
  localparam logic [2:0] ID_PIN_VALUE = 3'h2;
  localparam int ID_TEMP_POS = 5;
  localparam int ID_TEMP_W = 3;
  localparam int ID_PKG_POS = 3;
  localparam int ID_PKG_W = 2;
  localparam int ID_LEADFREE_POS = 2;
  localparam int ID_QUALIFICATION_STATE_POS = 0;
  localparam int ID_QUALIFICATION_STATE_W = 2;

  // Legal codes of the strapped fields
  localparam logic [2:0] TEMP_COMMERCIAL = 3'h0;
  localparam logic [2:0] TEMP_EXTENDED = 3'h2;
  localparam logic [1:0] PKG_SMALL_OUTLINE = 2'h0;
  localparam logic [1:0] PKG_BALL_GRID = 2'h2;
  localparam logic [1:0] QUALIFICATION_STATE_ENG_SAMPLE = 2'h0;
  localparam logic [1:0] QUALIFICATION_STATE_FULL = 2'h2;

  // Memory size word
  localparam int MEM_SRAM_POS = 16;
  localparam logic [15:0] MEM_SRAM_32K = 16'h007f;
  localparam logic [15:0] MEM_FLASH_128K = 16'h003f;
  localparam logic [31:0] MEM_SIZE_VALUE = {MEM_SRAM_32K, MEM_FLASH_128K};

  // Feature word one; positions shared with the matching gating registers
  localparam int F1_CAN_UNIT_ZERO_PRESENT = 24;
  localparam int F1_MINDIV_POS = 12;
  localparam logic [3:0] F1_MINDIV_VALUE = 4'h3;
  localparam int F1_MPU = 7;
  localparam int F1_HIB = 6;
  localparam int F1_PLL = 4;
  localparam int F1_WDT = 3;
  localparam int F1_SWO = 2;
  localparam int F1_SWD = 1;
  localparam int F1_JTAG = 0;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] FEATURE_ONE_VALUE = (ONE << F1_CAN_UNIT_ZERO_PRESENT)
      | ({28'h0000000, F1_MINDIV_VALUE} << F1_MINDIV_POS)
      | (ONE << F1_MPU) | (ONE << F1_HIB) | (ONE << F1_PLL) | (ONE << F1_WDT)
      | (ONE << F1_SWO) | (ONE << F1_SWD) | (ONE << F1_JTAG);

  // Peripheral word two; positions shared with the matching gating registers
  localparam int P2_COMPARATOR_ONE_PRESENT = 25;
  localparam int P2_COMPARATOR_ZERO_PRESENT = 24;
  localparam int P2_GP_TIMER_ZERO_PRESENT = 16;
  localparam int P2_TIMER_N = 4;
  localparam int P2_TWI1 = 14;
  localparam int P2_TWI0 = 12;
  localparam int P2_SYNC1 = 5;
  localparam int P2_SYNC0 = 4;
  localparam int P2_SERIAL0 = 0;
  localparam int P2_SERIAL_N = 3;

  typedef struct packed {
    logic sel;
    logic [1:0] trans;
    logic write;
    logic [2:0] size;
    logic [31:0] addr;
  } ahb_req_t;

  typedef struct packed {
    logic [2:0] temp;
    logic [1:0] pkg;
    logic [1:0] qualification_state;
  } strap_t;

  localparam strap_t STRAP_RESET = '{temp: 3'h0, pkg: 2'h0, qualification_state: 2'h0};

  typedef enum logic [1:0] {
    ST_LATCH = 2'b00,
    ST_READY = 2'b01
  } state_t;

endpackage

//--- design/capability_read_port.sv
`timescale 1ns/1ps
module capability_read_port (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Read request
  input wire logic rd_en,
  input wire logic [cap_pkg::OFF_W-1:0] rd_off,
  // Register contents
  input wire logic [31:0] id_word,
  input wire logic [31:0] mem_word,
  input wire logic [31:0] feat_word,
  input wire logic [31:0] periph_word,
  // Registered read data
  output logic [31:0] rdata_q
);

  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      case (rd_off)
        cap_pkg::OFF_DEVICE_ID_ONE: rdata_q <= id_word;
        cap_pkg::OFF_MEM_SIZE: rdata_q <= mem_word;
        cap_pkg::OFF_FEATURE_ONE: rdata_q <= feat_word;
        cap_pkg::OFF_PERIPH_TWO: rdata_q <= periph_word;
        // Holes in the window read as zero
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

endmodule

//--- design/device_capability_id_regs.sv
`timescale 1ns/1ps
// Operation
// - Temperature grade reads 0, 1 or 2 only; reserved codes never appear.
// - Package kind reads 0, 1 or 2 only; other codes reserved.
// - Lead-free flag always reads one.
// - Qualification state reads 0, 1 or 2 only; other codes reserved.
// - Memory word lower half reads the 128 KB flash code.
// - All capability words are fixed by the part and read-only.
// - Feature word one bit 24 shows CAN unit zero present.
// - Feature word one bit 4 shows the PLL present.
// - Feature word one bit 3 shows a watchdog present.
// - Feature word one bit 2 shows the trace output port present.
// - Feature word one bits 0 and 1 show JTAG and two-wire debug present.
// - Peripheral word two bits 14 and 12 set, bit 13 clear.
// - Peripheral word two bits 5 and 4 show both sync serial ports.
// - Peripheral word two bits 16 to 19 show timers zero to three.
// - Presence bits sit at the same positions as their gating bits.
module device_capability_id_regs #(
  // Arbitrary neutral identity values
  parameter logic [3:0] FAMILY_CODE = 4'h5,
  parameter logic [7:0] PART_CODE = 8'h3a,
  parameter int TIMER_COUNT = cap_pkg::P2_TIMER_N,
  parameter int SERIAL_COUNT = cap_pkg::P2_SERIAL_N
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  // Package straps, caught once after reset
  input wire logic [2:0] TEMP_GRADE_STRAP,
  input wire logic [1:0] PACKAGE_STRAP,
  input wire logic [1:0] QUALIFICATION_STATE_STRAP,
  // Status
  output logic ID_READY
);

  cap_pkg::ahb_req_t req;
  cap_pkg::strap_t strap_q;
  cap_pkg::strap_t strap_clean;
  cap_pkg::state_t state_q;
  logic ready_q;
  logic pend_q;
  logic [cap_pkg::OFF_W-1:0] pend_off_q;
  logic hreadyout_q;
  logic hresp_q;
  logic accept;
  logic rd_req;
  logic rd_en;
  logic [cap_pkg::OFF_W-1:0] req_off;
  logic [cap_pkg::OFF_W-1:0] rd_off;
  logic [31:0] id_word;
  logic [31:0] periph_word;

  assign req = '{sel: HSEL, trans: HTRANS, write: HWRITE, size: HSIZE, addr: HADDR};
  assign accept = req.sel && req.trans[1] && HREADY;
  // Writes are accepted with zero wait and dropped
  assign rd_req = accept && !req.write;
  // Any size reads the whole aligned word
  assign req_off = {req.addr[cap_pkg::OFF_W-1:cap_pkg::WORD_LSB], 2'b00};

  // Strap codes outside the legal set fall back to the safest legal code
  always_comb begin
    strap_clean.temp = (TEMP_GRADE_STRAP > cap_pkg::TEMP_EXTENDED) ?
        cap_pkg::TEMP_COMMERCIAL : TEMP_GRADE_STRAP;
    strap_clean.pkg = (PACKAGE_STRAP > cap_pkg::PKG_BALL_GRID) ?
        cap_pkg::PKG_SMALL_OUTLINE : PACKAGE_STRAP;
    strap_clean.qualification_state = (QUALIFICATION_STATE_STRAP > cap_pkg::QUALIFICATION_STATE_FULL) ?
        cap_pkg::QUALIFICATION_STATE_ENG_SAMPLE : QUALIFICATION_STATE_STRAP;
  end

  // Straps are sampled one clock after release, never under reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= cap_pkg::ST_LATCH;
    end else begin
      case (state_q)
        cap_pkg::ST_LATCH: state_q <= cap_pkg::ST_READY;
        cap_pkg::ST_READY: state_q <= cap_pkg::ST_READY;
        default: state_q <= cap_pkg::ST_LATCH;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      strap_q <= cap_pkg::STRAP_RESET;
    end else if (state_q == cap_pkg::ST_LATCH) begin
      strap_q <= strap_clean;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ready_q <= 1'b0;
    end else if (state_q == cap_pkg::ST_LATCH) begin
      ready_q <= 1'b1;
    end
  end

  // Identification word; reserved field 12:8 stays zero
  always_comb begin
    id_word = 32'h0000_0000;
    id_word[cap_pkg::ID_VER_POS +: cap_pkg::ID_VER_W] = cap_pkg::ID_VER_VALUE;
    id_word[cap_pkg::ID_FAM_POS +: cap_pkg::ID_FAM_W] = FAMILY_CODE;
    id_word[cap_pkg::ID_PART_POS +: cap_pkg::ID_PART_W] = PART_CODE;
    id_word[cap_pkg::ID_PIN_POS +: cap_pkg::ID_PIN_W] = cap_pkg::ID_PIN_VALUE;
    id_word[cap_pkg::ID_TEMP_POS +: cap_pkg::ID_TEMP_W] = strap_q.temp;
    id_word[cap_pkg::ID_PKG_POS +: cap_pkg::ID_PKG_W] = strap_q.pkg;
    id_word[cap_pkg::ID_LEADFREE_POS] = 1'b1;
    id_word[cap_pkg::ID_QUALIFICATION_STATE_POS +: cap_pkg::ID_QUALIFICATION_STATE_W] = strap_q.qualification_state;
  end

  // Peripheral word; unit groups repeat per instance
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_periph
      if (gi == cap_pkg::P2_COMPARATOR_ONE_PRESENT || gi == cap_pkg::P2_COMPARATOR_ZERO_PRESENT) begin : g_comp
        assign periph_word[gi] = 1'b1;
      end else if (gi >= cap_pkg::P2_GP_TIMER_ZERO_PRESENT && gi < cap_pkg::P2_GP_TIMER_ZERO_PRESENT + TIMER_COUNT)
      begin : g_timer
        assign periph_word[gi] = 1'b1;
      end else if (gi == cap_pkg::P2_TWI1 || gi == cap_pkg::P2_TWI0) begin : g_twi
        assign periph_word[gi] = 1'b1;
      end else if (gi == cap_pkg::P2_SYNC1 || gi == cap_pkg::P2_SYNC0) begin : g_sync
        assign periph_word[gi] = 1'b1;
      end else if (gi >= cap_pkg::P2_SERIAL0 && gi < cap_pkg::P2_SERIAL0 + SERIAL_COUNT)
      begin : g_serial
        assign periph_word[gi] = 1'b1;
      end else begin : g_rsvd
        // Includes bit 13 between the two-wire units
        assign periph_word[gi] = 1'b0;
      end
    end
  endgenerate

  // A read taken before the straps settle is held and served late
  always_ff @(posedge CLK) begin
    if (RST) begin
      pend_q <= 1'b0;
    end else if (rd_req && !ready_q) begin
      pend_q <= 1'b1;
    end else if (ready_q) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      pend_off_q <= '0;
    end else if (rd_req && !ready_q) begin
      pend_off_q <= req_off;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      hreadyout_q <= 1'b1;
    end else if (rd_req && !ready_q) begin
      hreadyout_q <= 1'b0;
    end else if (pend_q && ready_q) begin
      hreadyout_q <= 1'b1;
    end
  end

  // Every transfer ends OKAY
  always_ff @(posedge CLK) begin
    if (RST) begin
      hresp_q <= 1'b0;
    end else begin
      hresp_q <= 1'b0;
    end
  end

  assign rd_en = ready_q && (rd_req || pend_q);
  assign rd_off = pend_q ? pend_off_q : req_off;

  capability_read_port u_read (
    .CLK(CLK),
    .RST(RST),
    .rd_en(rd_en),
    .rd_off(rd_off),
    .id_word(id_word),
    .mem_word(cap_pkg::MEM_SIZE_VALUE),
    .feat_word(cap_pkg::FEATURE_ONE_VALUE),
    .periph_word(periph_word),
    .rdata_q(HRDATA)
  );

  assign HREADYOUT = hreadyout_q;
  assign HRESP = hresp_q;
  assign ID_READY = ready_q;

endmodule

//--- dv/cap_checker.sv
`timescale 1ns/1ps
module cap_checker #(
  parameter logic [3:0] FAMILY_CODE = 4'h5,
  parameter logic [7:0] PART_CODE = 8'h3a
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [31:0] HRDATA,
  // Status
  input wire logic ID_READY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic go;
  logic rd_go;
  logic [9:0] word;
  assign go = HSEL && HTRANS[1] && HREADY;
  // Stalled reads are judged by the bench, the straps are not known here
  assign rd_go = go && !HWRITE && ID_READY;
  assign word = HADDR[11:2];
  okay_resp_a: assert property (HRESP == 1'b0) else $error("error response");
  short_stall_a: assert property (!HREADYOUT |=> HREADYOUT) else $error("long stall");
  id_held_a: assert property (ID_READY |=> ID_READY) else $error("straps lost");
  ready_timing_a: assert property ($fell(RST) |-> !ID_READY ##1 ID_READY)
    else $error("ready timing");
  id_fixed_a: assert property (rd_go && word == 10'h001 |=>
    HRDATA[31:13] == {4'h1, FAMILY_CODE, PART_CODE, 3'h2} && HRDATA[12:8] == 5'h00 && HRDATA[2])
    else $error("id fixed fields");
  temp_code_a: assert property (rd_go && word == 10'h001 |=> HRDATA[7:5] <= 3'h2)
    else $error("temp code");
  pkg_code_a: assert property (rd_go && word == 10'h001 |=> HRDATA[4:3] != 2'h3)
    else $error("package code");
  qualification_state_code_a: assert property (rd_go && word == 10'h001 |=> HRDATA[1:0] != 2'h3)
    else $error("qualification_state code");
  mem_word_a: assert property (rd_go && word == 10'h002 |=> HRDATA == 32'h007f003f)
    else $error("memory word");
  feat_word_a: assert property (rd_go && word == 10'h004 |=> HRDATA == 32'h010030df)
    else $error("feature word");
  periph_word_a: assert property (rd_go && word == 10'h005 |=> HRDATA == 32'h030f5037)
    else $error("peripheral word");
  write_ignored_a: assert property (go && HWRITE |=> $stable(HRDATA))
    else $error("write had effect");
  cover property (!HREADYOUT);
  cover property (go && HWRITE);
  cover property (rd_go && word == 10'h005);
endmodule

//--- dv/test_device_capability_id_regs.sv
`timescale 1ns/1ps
module test_device_capability_id_regs;
  localparam logic [3:0] FAM = 4'h6;
  localparam logic [7:0] PART = 8'h4c;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0;
  logic [2:0] TEMP_GRADE_STRAP = 3'h0;
  logic [1:0] PACKAGE_STRAP = 2'h0;
  logic [1:0] QUALIFICATION_STATE_STRAP = 2'h0;
  wire HREADYOUT;
  wire HRESP;
  wire ID_READY;
  wire [31:0] HRDATA;
  logic [31:0] seed = 32'h7849574e;
  logic [31:0] id_exp;
  logic [31:0] addrs [8] = '{32'h4, 32'h8, 32'h10, 32'h14, 32'h0, 32'hc, 32'h18, 32'hffc};
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  always #12.5 CLK = ~CLK;

  device_capability_id_regs #(.FAMILY_CODE(FAM), .PART_CODE(PART)) dut (
    .CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .HRDATA(HRDATA), .TEMP_GRADE_STRAP(TEMP_GRADE_STRAP), .PACKAGE_STRAP(PACKAGE_STRAP),
    .QUALIFICATION_STATE_STRAP(QUALIFICATION_STATE_STRAP), .ID_READY(ID_READY));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Reserved strap codes are clamped to zero
  function automatic logic [31:0] exp_id(input logic [2:0] t, input logic [1:0] p, q);
    return {4'h1, FAM, PART, 3'h2, 5'h00, (t > 3'h2) ? 3'h0 : t, (p == 2'h3) ? 2'h0 : p,
      1'b1, (q == 2'h3) ? 2'h0 : q};
  endfunction

  function automatic logic [31:0] exp_reg(input logic [31:0] a);
    case (a[11:2])
      10'h001: return id_exp;
      10'h002: return 32'h007f003f;
      10'h004: return 32'h010030df;
      10'h005: return 32'h030f5037;
      default: return 32'h0;
    endcase
  endfunction

  task automatic chk(input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: read %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Ready and data are looked at before the edge that takes them
  task automatic xfer(input logic w, input logic [31:0] a, wd, output logic [31:0] rd);
    logic rdy;
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    do begin
      @(negedge CLK) rdy = HREADYOUT;
      @(posedge CLK);
    end while (rdy !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do begin
      @(negedge CLK) rdy = HREADYOUT;
      rd = HRDATA;
      @(posedge CLK);
    end while (rdy !== 1'b1);
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      $display("unexpected at %0t: run hung", $time);
      give_verdict();
    end
  end

  initial begin
    logic [31:0] r;
    logic [31:0] rd;
    logic [31:0] a;
    logic [2:0] t;
    logic [1:0] p;
    logic [1:0] q;
    logic w;
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      t = (i < 3) ? 3'(i) : (i == 3) ? 3'h7 : r[2:0];
      p = (i < 3) ? 2'(i) : (i == 3) ? 2'h3 : r[4:3];
      q = (i < 3) ? 2'(i) : (i == 3) ? 2'h3 : r[6:5];
      RST <= 1'b1;
      TEMP_GRADE_STRAP <= t;
      PACKAGE_STRAP <= p;
      QUALIFICATION_STATE_STRAP <= q;
      repeat (10) @(posedge CLK);
      RST <= 1'b0;
      id_exp = exp_id(t, p, q);
      xfer(1'b0, 32'h4, 32'h0, rd);
      chk(rd, id_exp);
      TEMP_GRADE_STRAP <= ~t;
      PACKAGE_STRAP <= ~p;
      QUALIFICATION_STATE_STRAP <= r[9:8];
      xfer(1'b0, 32'h4, 32'h0, rd);
      chk(rd, id_exp);
    end
    $display("strap test done");
    for (int i = 0; i < 56; i++) begin
      r = rnd();
      w = (i < 16) ? !i[0] : r[3];
      a = addrs[(i < 16) ? i[3:1] : r[2:0]];
      // Sizes below a word still return the whole word
      HSIZE <= 3'(r[5:4]);
      // Writes leave reserved bits as they read
      xfer(w, a, rnd() & exp_reg(a), rd);
      if (!w) chk(rd, exp_reg(a));
    end
    $display("register test done");
    give_verdict();
  end
endmodule

bind device_capability_id_regs cap_checker #(.FAMILY_CODE(FAMILY_CODE), .PART_CODE(PART_CODE))
  chk_i (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .ID_READY(ID_READY));
